//--- common/err_pkg.sv
// Shared constants and types for the link error reporting block
package err_pkg;
    // Register byte addresses (byte address = index * 4)
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_BRCTL = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_SSTAT = 8'h0c;
    localparam logic [7:0] A_ERRST = 8'h10;
    localparam logic [7:0] A_ERRHND = 8'h14;
    // Command bits
    localparam int B_DERESP = 0;
    localparam int B_SERREN = 1;
    // Bridge control bits
    localparam int B_MAMODE = 2;
    // Status / secondary status bits
    localparam int B_SIGTA = 0;
    localparam int B_RXTA = 1;
    localparam int B_RXMA = 2;
    localparam int B_MDERR = 3;
    localparam int B_DEDET = 4;
    localparam int B_SIGSE = 5;
    localparam int B_DETSE = 6;
    // Error status bits
    localparam int B_RESPERR = 0;
    localparam int B_CHFAIL = 1;
    localparam int B_SERRINT = 2;
    // Error handling enable bits
    localparam int B_RFATAL = 0;
    localparam int B_RNONF = 1;
    localparam int B_SFATAL = 2;
    localparam int B_SNONF = 3;
    localparam int REG_W = 8;
    // Error field codes carried in a response
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_DE = 2'h1;
    localparam logic [1:0] ERR_TA = 2'h2;
    localparam logic [1:0] ERR_MA = 2'h3;
    localparam logic [3:0] ATOMIC_CNT = 4'h1;
    // Link bit time 125 ns as a reference; sync seen after this many all-ones bit times
    localparam int SYNC_TIMES = 4;

    typedef enum logic [1:0] {REQ_WR, REQ_FLUSH, REQ_RD, REQ_ATOMIC} req_kind_e;

    typedef struct packed {
        logic [4:0] transaction_tag;
        req_kind_e kind;
        logic [3:0] count;
    } req_s;

    typedef struct packed {
        logic [4:0] transaction_tag;
        logic is_read_data;
        logic [3:0] count;
        logic [1:0] err;
        logic secondary;
    } rsp_s;
endpackage

//--- core/link_err_report.sv
// Error detection, logging and sync flood control for one link node
`timescale 1ns/1ps
module link_err_report
    import err_pkg::*;
#(
    parameter int LANES = 8,
    parameter int TAGS = 32,
    parameter bit IS_BRIDGE = 1'b1,
    parameter bit HAS_FATAL = 1'b1,
    parameter bit HAS_NONFATAL = 1'b1
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic warm_rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic retry_mode,
    input wire logic req_valid,
    input wire req_s req,
    input wire logic rsp_valid,
    input wire rsp_s rsp,
    input wire logic crc_ok,
    input wire logic crc_bad,
    input wire logic tx_ta,
    input wire logic tx_ta_sec,
    input wire logic tx_td_derr,
    input wire logic tx_td_derr_sec,
    input wire logic rx_post_derr,
    input wire logic rx_post_derr_sec,
    input wire logic tx_post_derr,
    input wire logic tx_post_derr_sec,
    input wire logic flood_err,
    input wire logic sec_int_err,
    input wire logic fwd_valid,
    input wire logic [1:0] fwd_err,
    output logic fwd_out_valid,
    output logic [1:0] fwd_out_err,
    output logic fwd_data_ones,
    input wire logic link_clk,
    input wire logic pri_init_done,
    input wire logic sec_init_done,
    input wire logic [LANES-1:0] pri_rx_cad,
    input wire logic pri_rx_ctl,
    input wire logic [LANES-1:0] sec_rx_cad,
    input wire logic sec_rx_ctl,
    input wire logic [LANES-1:0] pri_tx_cad_in,
    input wire logic pri_tx_ctl_in,
    input wire logic [LANES-1:0] sec_tx_cad_in,
    input wire logic sec_tx_ctl_in,
    output logic [LANES-1:0] pri_tx_cad,
    output logic pri_tx_ctl,
    output logic [LANES-1:0] sec_tx_cad,
    output logic sec_tx_ctl,
    output logic pri_crc_gen_en,
    output logic sec_crc_gen_en,
    output logic pri_crc_chk_en,
    output logic sec_crc_chk_en,
    output logic fatal_int,
    output logic nonfatal_int
);
    localparam int SW = LANES + 2;

    // ******************************************
    // Link input sampling
    // ******************************************
    // Bundle: link clock, ctl, cad for each receiver
    logic [2*SW-1:0] raw;
    logic [2*SW-1:0] s1_r;
    logic [2*SW-1:0] s2_r;
    logic [2*SW-1:0] s3_r;
    logic [2*SW-1:0] stab_r;
    logic lclk_prev_r;
    logic link_edge;
    assign raw = {link_clk, pri_rx_ctl, pri_rx_cad, link_clk, sec_rx_ctl, sec_rx_cad};

    // Three stages; a bit changes only once stages two and three agree
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            {s1_r, s2_r, s3_r} <= '0;
        else
            {s1_r, s2_r, s3_r} <= {raw, s1_r, s2_r};
    end

    // Stable copy of each sampled bit
    genvar gi;
    generate
        for (gi = 0; gi < 2*SW; gi++)
        begin : g_stab
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    stab_r[gi] <= 1'b0;
                else if (s2_r[gi] == s3_r[gi])
                    stab_r[gi] <= s3_r[gi];
            end
        end
    endgenerate

    // Rising link clock edge found in the local domain
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lclk_prev_r <= 1'b0;
        else
            lclk_prev_r <= stab_r[2*SW-1];
    end
    assign link_edge = stab_r[2*SW-1] && !lclk_prev_r;

    // ******************************************
    // Sync packet detection per receiver
    // ******************************************
    logic [2:0] pri_cnt_r;
    logic [2:0] sec_cnt_r;
    logic pri_seen_r;
    logic sec_seen_r;
    logic pri_ones;
    logic sec_ones;
    assign pri_ones = &stab_r[2*SW-2:SW];
    assign sec_ones = &stab_r[SW-2:0];

    // All ones for several bit times means flood; only after init completes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            {pri_cnt_r, sec_cnt_r, pri_seen_r, sec_seen_r} <= '0;
        else if (warm_rst)
            {pri_cnt_r, sec_cnt_r, pri_seen_r, sec_seen_r} <= '0;
        else if (link_edge)
        begin
            pri_cnt_r <= (pri_ones && pri_init_done) ? pri_cnt_r + 3'h1 : '0;
            sec_cnt_r <= (sec_ones && sec_init_done && IS_BRIDGE) ? sec_cnt_r + 3'h1 : '0;
            if (pri_cnt_r == 3'(SYNC_TIMES - 1))
                pri_seen_r <= 1'b1;
            if (sec_cnt_r == 3'(SYNC_TIMES - 1))
                sec_seen_r <= 1'b1;
        end
    end

    // ******************************************
    // Control registers
    // ******************************************
    logic [REG_W-1:0] cmd_r;
    logic [REG_W-1:0] brctl_r;
    logic [REG_W-1:0] errhnd_r;
    logic [REG_W-1:0] en_mask;
    assign en_mask = {4'h0, HAS_NONFATAL, HAS_FATAL, HAS_NONFATAL, HAS_FATAL};

    // Plain read/write control; survive warm reset like the status
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_r <= '0;
            brctl_r <= '0;
            errhnd_r <= '0;
        end
        else if (wr)
        begin
            if (addr == A_CMD)
                cmd_r <= wdata[REG_W-1:0];
            if (addr == A_BRCTL)
                brctl_r <= wdata[REG_W-1:0];
            if (addr == A_ERRHND)
                errhnd_r <= wdata[REG_W-1:0] & en_mask;
        end
    end

    // ******************************************
    // Outstanding request table
    // ******************************************
    logic [TAGS-1:0] out_v_r;
    req_kind_e kind_mem [TAGS];
    logic [3:0] cnt_mem [TAGS];
    logic mismatch;
    req_kind_e k;

    always_ff @(posedge clk)
    begin
        if (req_valid)
        begin
            kind_mem[req.transaction_tag] <= req.kind;
            cnt_mem[req.transaction_tag] <= req.count;
        end
    end

    // Entry freed when its response arrives; new request wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            out_v_r <= '0;
        else if (warm_rst)
            out_v_r <= '0;
        else
        begin
            if (rsp_valid)
                out_v_r[rsp.transaction_tag] <= 1'b0;
            if (req_valid)
                out_v_r[req.transaction_tag] <= 1'b1;
        end
    end

    // Response against its request
    always_comb
    begin
        k = kind_mem[rsp.transaction_tag];
        mismatch = 1'b0;
        if (!out_v_r[rsp.transaction_tag])
            mismatch = 1'b1;
        else if (rsp.is_read_data && (k == REQ_WR || k == REQ_FLUSH))
            mismatch = 1'b1;
        else if (!rsp.is_read_data && (k == REQ_RD || k == REQ_ATOMIC))
            mismatch = 1'b1;
        else if (rsp.is_read_data && k == REQ_RD && rsp.count != cnt_mem[rsp.transaction_tag])
            mismatch = 1'b1;
        else if (rsp.is_read_data && k == REQ_ATOMIC && rsp.count != ATOMIC_CNT)
            mismatch = 1'b1;
    end

    // ******************************************
    // Response error logging
    // ******************************************
    logic pend_r;
    logic resp_log;

    // hold error until CRC validated in retry mode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pend_r <= 1'b0;
        else if (rsp_valid && mismatch && retry_mode)
            pend_r <= 1'b1;
        else if (crc_ok || crc_bad || !retry_mode)
            pend_r <= 1'b0;
    end
    assign resp_log = (rsp_valid && mismatch && !retry_mode) || (pend_r && crc_ok);

    // ******************************************
    // Flood control
    // ******************************************
    logic pri_flood_r;
    logic sec_flood_r;
    logic sec_own_r;
    logic start_pri;
    logic sec_up;
    logic serr_conv;

    // initiation gated by system error enable
    assign start_pri = flood_err && cmd_r[B_SERREN] && !pri_flood_r;
    // secondary flood forwarded up only with both enables
    assign sec_up = sec_seen_r && brctl_r[B_SERREN] && cmd_r[B_SERREN];
    assign serr_conv = IS_BRIDGE && sec_seen_r && !sec_own_r && !sec_up;

    // a seen primary flood drives both transmitters; a seen secondary one drives primary only with sec_up
    // only warm or cold reset ends a flood
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            {pri_flood_r, sec_flood_r, sec_own_r} <= '0;
        else if (warm_rst)
            {pri_flood_r, sec_flood_r, sec_own_r} <= '0;
        else
        begin
            if (start_pri || pri_seen_r || (IS_BRIDGE ? sec_up : sec_seen_r))
                pri_flood_r <= 1'b1;
            // primary flood and internal errors reach secondary
            if (IS_BRIDGE && (pri_flood_r || sec_int_err || sec_seen_r))
                sec_flood_r <= 1'b1;
            if (IS_BRIDGE && sec_int_err && !sec_seen_r)
                sec_own_r <= 1'b1;
        end
    end

    // ******************************************
    // Status registers
    // ******************************************
    logic [REG_W-1:0] stat_r;
    logic [REG_W-1:0] sstat_r;
    logic [REG_W-1:0] errst_r;
    logic [REG_W-1:0] stat_set;
    logic [REG_W-1:0] sstat_set;
    logic [REG_W-1:0] errst_set;
    logic pri_rsp;
    logic sec_rsp;
    assign pri_rsp = rsp_valid && !(IS_BRIDGE && rsp.secondary);
    assign sec_rsp = rsp_valid && IS_BRIDGE && rsp.secondary;

    // Event to bit mapping, primary and secondary side
    always_comb
    begin
        stat_set = '0;
        sstat_set = '0;
        errst_set = '0;
        stat_set[B_RXTA] = pri_rsp && rsp.err == ERR_TA;
        sstat_set[B_RXTA] = sec_rsp && rsp.err == ERR_TA;
        stat_set[B_RXMA] = pri_rsp && rsp.err == ERR_MA;
        sstat_set[B_RXMA] = sec_rsp && rsp.err == ERR_MA;
        stat_set[B_SIGTA] = tx_ta;
        sstat_set[B_SIGTA] = tx_ta_sec && IS_BRIDGE;
        // data error response received or driven
        stat_set[B_MDERR] = cmd_r[B_DERESP] && ((pri_rsp && rsp.err == ERR_DE) || tx_post_derr);
        sstat_set[B_MDERR] = brctl_r[B_DERESP] && ((sec_rsp && rsp.err == ERR_DE) || (tx_post_derr_sec && IS_BRIDGE));
        stat_set[B_DEDET] = tx_td_derr || rx_post_derr;
        sstat_set[B_DEDET] = IS_BRIDGE && (tx_td_derr_sec || rx_post_derr_sec);
        stat_set[B_SIGSE] = start_pri;
        // detected system error unless own flood
        sstat_set[B_DETSE] = IS_BRIDGE && sec_seen_r && !sec_own_r;
        errst_set[B_RESPERR] = resp_log;
        errst_set[B_CHFAIL] = pri_flood_r || sec_flood_r;
        errst_set[B_SERRINT] = serr_conv;
    end

    // Write one to clear; set wins; no warm reset clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            {stat_r, sstat_r, errst_r} <= '0;
        else
        begin
            stat_r <= (stat_r & ~((wr && addr == A_STAT) ? wdata[REG_W-1:0] : '0)) | stat_set;
            sstat_r <= (sstat_r & ~((wr && addr == A_SSTAT) ? wdata[REG_W-1:0] : '0)) | sstat_set;
            errst_r <= (errst_r & ~((wr && addr == A_ERRST) ? wdata[REG_W-1:0] : '0)) | errst_set;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= '0;
        else if (rd)
        begin
            unique case (addr)
                A_CMD: rdata <= {24'h0, cmd_r};
                A_BRCTL: rdata <= {24'h0, brctl_r};
                A_STAT: rdata <= {24'h0, stat_r};
                A_SSTAT: rdata <= {24'h0, sstat_r};
                A_ERRST: rdata <= {24'h0, errst_r};
                A_ERRHND: rdata <= {24'h0, errhnd_r};
                default: rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end

    // ******************************************
    // Transmit side and interrupt pins
    // ******************************************
    // flood forces lanes to ones
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {pri_tx_cad, pri_tx_ctl, sec_tx_cad, sec_tx_ctl} <= '0;
            {pri_crc_gen_en, sec_crc_gen_en, pri_crc_chk_en, sec_crc_chk_en} <= '0;
        end
        else
        begin
            pri_tx_cad <= pri_flood_r ? '1 : pri_tx_cad_in;
            pri_tx_ctl <= pri_flood_r | pri_tx_ctl_in;
            sec_tx_cad <= sec_flood_r ? '1 : sec_tx_cad_in;
            sec_tx_ctl <= sec_flood_r | sec_tx_ctl_in;
            pri_crc_gen_en <= !pri_flood_r;
            sec_crc_gen_en <= !sec_flood_r;
            pri_crc_chk_en <= !pri_seen_r;
            sec_crc_chk_en <= !sec_seen_r;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            {fatal_int, nonfatal_int} <= '0;
        else
        begin
            fatal_int <= (errst_r[B_RESPERR] && errhnd_r[B_RFATAL]) || (errst_r[B_SERRINT] && errhnd_r[B_SFATAL]);
            nonfatal_int <= (errst_r[B_RESPERR] && errhnd_r[B_RNONF]) || (errst_r[B_SERRINT] && errhnd_r[B_SNONF]);
        end
    end

    // ******************************************
    // Bridge response forwarding
    // ******************************************
    // master abort becomes normal or target abort
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fwd_out_valid <= 1'b0;
            fwd_out_err <= ERR_NONE;
            fwd_data_ones <= 1'b0;
        end
        else
        begin
            fwd_out_valid <= fwd_valid;
            if (fwd_err == ERR_MA)
                fwd_out_err <= brctl_r[B_MAMODE] ? ERR_TA : ERR_NONE;
            else
                fwd_out_err <= fwd_err;
            fwd_data_ones <= fwd_valid && fwd_err == ERR_MA;
        end
    end
endmodule

//--- sim/link_err_report_chk.sv
// Assertion checker bound to the link error block
`timescale 1ns/1ps
module link_err_report_chk
    import err_pkg::*;
#(
    parameter int LANES = 8
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic warm_rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic fwd_valid,
    input wire logic [1:0] fwd_err,
    input wire logic fwd_out_valid,
    input wire logic [1:0] fwd_out_err,
    input wire logic fwd_data_ones,
    input wire logic flood_err,
    input wire logic pri_rx_ctl,
    input wire logic sec_rx_ctl,
    input wire logic [LANES-1:0] pri_tx_cad,
    input wire logic pri_tx_ctl,
    input wire logic [LANES-1:0] sec_tx_cad,
    input wire logic pri_crc_gen_en,
    input wire logic sec_crc_gen_en,
    input wire logic fatal_int,
    input wire logic nonfatal_int
);
    logic cmd_serr_r;
    logic ma_mode_r;
    logic [3:0] errhnd_r;
    logic pri_ones;
    logic sec_ones;
    // Sync pattern on the primary transmitter; all-ones cad lanes on the secondary
    assign pri_ones = &pri_tx_cad & pri_tx_ctl;
    assign sec_ones = &sec_tx_cad;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Shadow of the control bits, since the checker cannot see registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_serr_r <= 1'b0;
            ma_mode_r <= 1'b0;
            errhnd_r <= 4'h0;
        end
        else if (wr)
        begin
            if (addr == A_CMD)
                cmd_serr_r <= wdata[B_SERREN];
            if (addr == A_BRCTL)
                ma_mode_r <= wdata[B_MAMODE];
            if (addr == A_ERRHND)
                errhnd_r <= wdata[3:0];
        end
    end
    flood_hold_a: assert property (pri_ones |=> pri_ones || $past(warm_rst) || $past(warm_rst, 2))
        else $error("flood dropped without warm reset");
    pri_nocrc_a: assert property ($rose(pri_ones) |-> ##[0:2] !pri_crc_gen_en)
        else $error("primary crc generated while flooding");
    sec_nocrc_a: assert property ($rose(sec_ones) |-> ##[0:2] !sec_crc_gen_en)
        else $error("secondary crc generated while flooding");
    ta_pass_a: assert property (fwd_valid && fwd_err == ERR_TA |=> fwd_out_valid && fwd_out_err == ERR_TA && !fwd_data_ones)
        else $error("target abort not forwarded unchanged");
    ma_conv_a: assert property (fwd_valid && fwd_err == ERR_MA |=>
        fwd_out_valid && fwd_data_ones && fwd_out_err == (ma_mode_r ? ERR_TA : ERR_NONE))
        else $error("master abort conversion wrong");
    sec_follow_a: assert property ($rose(pri_ones) |-> ##[0:4] sec_ones)
        else $error("secondary not flooded after primary");
    serr_gate_a: assert property (flood_err && !cmd_serr_r && !pri_rx_ctl && !sec_rx_ctl && !pri_ones |=> !pri_ones)
        else $error("flood started without system error enable");
    int_off_a: assert property (errhnd_r == 4'h0 && $past(errhnd_r) == 4'h0 |-> !fatal_int && !nonfatal_int)
        else $error("interrupt raised with enables clear");
endmodule
bind link_err_report link_err_report_chk #(.LANES(LANES)) u_chk (.clk(clk), .rstn(rstn), .warm_rst(warm_rst),
    .addr(addr), .wdata(wdata), .wr(wr), .fwd_valid(fwd_valid), .fwd_err(fwd_err), .fwd_out_valid(fwd_out_valid),
    .fwd_out_err(fwd_out_err), .fwd_data_ones(fwd_data_ones), .flood_err(flood_err), .pri_rx_ctl(pri_rx_ctl),
    .sec_rx_ctl(sec_rx_ctl), .pri_tx_cad(pri_tx_cad), .pri_tx_ctl(pri_tx_ctl), .sec_tx_cad(sec_tx_cad),
    .pri_crc_gen_en(pri_crc_gen_en), .sec_crc_gen_en(sec_crc_gen_en), .fatal_int(fatal_int),
    .nonfatal_int(nonfatal_int));

//--- sim/link_peer.sv
// Neighbouring link node model driving both receive sides of the block
`timescale 1ns/1ps
module link_peer #(
    parameter int LANES = 8
)(
    input wire logic flood_pri,
    input wire logic flood_sec,
    output logic link_clk,
    output logic [LANES-1:0] pri_cad,
    output logic pri_ctl,
    output logic [LANES-1:0] sec_cad,
    output logic sec_ctl
);
    logic [LANES-1:0] pat;
    // Link clock stands still unless a side is flooding; odd offset keeps it unrelated to clk
    initial
    begin
        link_clk = 1'b0;
        pat = {(LANES/4){4'h5}};
        #3.1;
        forever
        begin
            #62.5;
            if (flood_pri || flood_sec)
                link_clk = ~link_clk;
        end
    end
    // Normal traffic changes every bit time, never all ones
    always @(posedge link_clk)
        pat <= ~pat;
    // all lanes ones, held until told
    assign pri_cad = flood_pri ? '1 : pat;
    assign pri_ctl = flood_pri;
    assign sec_cad = flood_sec ? '1 : pat;
    assign sec_ctl = flood_sec;
endmodule

//--- sim/tb_link_err_report.sv
// Self-checking testbench for the link error reporting block
`timescale 1ns/1ps
module tb_link_err_report
    import err_pkg::*;
();
    logic clk = 1'b0;
    logic rstn = 1'b0, warm_rst = 1'b0, wr = 1'b0, rd = 1'b0, retry_mode = 1'b0, req_valid = 1'b0;
    logic rsp_valid = 1'b0, crc_ok = 1'b0, crc_bad = 1'b0, flood_err = 1'b0, fwd_valid = 1'b0;
    logic init_done = 1'b0, flood_pri = 1'b0, flood_sec = 1'b0;
    logic [7:0] addr = 8'h00, ev = 8'h00, tx_in = 8'h3c;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] fwd_err = 2'h0, fwd_out_err;
    req_s req = '0;
    rsp_s rsp = '0;
    logic [7:0] pri_rx_cad, sec_rx_cad, pri_tx_cad, sec_tx_cad;
    logic link_clk, pri_rx_ctl, sec_rx_ctl, pri_tx_ctl, sec_tx_ctl, fwd_out_valid, fatal_int, nonfatal_int;
    logic pri_gen, sec_gen, pri_chk, sec_chk, fwd_data_ones;
    int n_errors = 0, tests_run = 0;
    // Response check cases: request kind, response count, read data or not, error expected
    req_kind_e kt[10] = '{REQ_WR, REQ_WR, REQ_FLUSH, REQ_RD, REQ_ATOMIC, REQ_RD, REQ_ATOMIC, REQ_RD, REQ_ATOMIC, REQ_WR};
    logic [3:0] ct[10] = '{4'h3, 4'h1, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h3, 4'h1, 4'h3};
    logic [0:9] rdv = 10'h39e, ex = 10'h3f8;
    logic [1:0] ec[3] = '{ERR_TA, ERR_MA, ERR_DE};
    int eb[3] = '{B_RXTA, B_RXMA, B_MDERR};

    always #5 clk = ~clk;
    // Normal transmit data, never the sync pattern
    always @(posedge clk)
        tx_in <= ~tx_in;

    link_err_report i_dut (.clk(clk), .rstn(rstn), .warm_rst(warm_rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .retry_mode(retry_mode), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
        .rsp(rsp), .crc_ok(crc_ok), .crc_bad(crc_bad), .tx_ta(ev[0]), .tx_ta_sec(ev[1]), .tx_td_derr(ev[2]),
        .tx_td_derr_sec(ev[3]), .rx_post_derr(ev[4]), .rx_post_derr_sec(ev[5]), .tx_post_derr(ev[6]),
        .tx_post_derr_sec(ev[7]), .flood_err(flood_err), .sec_int_err(flood_err), .fwd_valid(fwd_valid),
        .fwd_err(fwd_err), .fwd_out_valid(fwd_out_valid), .fwd_out_err(fwd_out_err), .fwd_data_ones(fwd_data_ones),
        .link_clk(link_clk), .pri_init_done(init_done), .sec_init_done(init_done), .pri_rx_cad(pri_rx_cad),
        .pri_rx_ctl(pri_rx_ctl), .sec_rx_cad(sec_rx_cad), .sec_rx_ctl(sec_rx_ctl), .pri_tx_cad_in(tx_in),
        .pri_tx_ctl_in(1'b0), .sec_tx_cad_in(tx_in), .sec_tx_ctl_in(1'b0), .pri_tx_cad(pri_tx_cad),
        .pri_tx_ctl(pri_tx_ctl), .sec_tx_cad(sec_tx_cad), .sec_tx_ctl(sec_tx_ctl), .pri_crc_gen_en(pri_gen),
        .sec_crc_gen_en(sec_gen), .pri_crc_chk_en(pri_chk), .sec_crc_chk_en(sec_chk), .fatal_int(fatal_int),
        .nonfatal_int(nonfatal_int));

    link_peer i_peer (.flood_pri(flood_pri), .flood_sec(flood_sec), .link_clk(link_clk), .pri_cad(pri_rx_cad),
        .pri_ctl(pri_rx_ctl), .sec_cad(sec_rx_cad), .sec_ctl(sec_rx_ctl));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // One register access; for a read, d is the expected word
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input string n);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w)
            chk(n, d, rdata);
    endtask

    // Optional request, then its response on the next cycle
    task automatic send(input logic q, input req_s r, input rsp_s s);
        @(posedge clk);
        req <= r;
        req_valid <= q;
        @(posedge clk);
        req_valid <= 1'b0;
        rsp <= s;
        rsp_valid <= 1'b1;
        @(posedge clk);
        rsp_valid <= 1'b0;
    endtask

    // One-cycle warm reset (w) or flood request, which is also the internal secondary error
    task automatic pulse(input bit w);
        @(posedge clk);
        warm_rst <= w;
        flood_err <= !w;
        @(posedge clk);
        warm_rst <= 1'b0;
        flood_err <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    // Watchdog, far beyond the expected run length
    initial
    begin
        #200000;
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        init_done <= 1'b1;
        acc(0, 8'h3c, 32'h0, "unmapped");
        acc(1, A_CMD, 32'h3, "");
        acc(1, A_BRCTL, 32'h7, "");
        acc(1, A_ERRHND, 32'h1, "");
        // Mismatched and matching responses, one tag per case
        for (int i = 0; i < 10; i++)
        begin
            send(i != 0, '{5'(i), kt[i], (kt[i] == REQ_ATOMIC) ? ATOMIC_CNT : 4'h3}, '{5'(i), rdv[i], ct[i], ERR_NONE, 1'b0});
            acc(0, A_ERRST, {31'h0, ex[i]}, "resp_err");
            chk("fatal_int", {31'h0, ex[i]}, {31'h0, fatal_int});
            acc(1, A_ERRST, 32'h1, "");
        end
        // Retry mode: log waits for a good CRC, a bad one drops it
        retry_mode <= 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            send(1'b0, '0, '{5'h10, 1'b1, 4'h3, ERR_NONE, 1'b0});
            acc(0, A_ERRST, 32'h0, "retry_hold");
            @(posedge clk);
            crc_ok <= j[0];
            crc_bad <= !j[0];
            @(posedge clk);
            crc_ok <= 1'b0;
            crc_bad <= 1'b0;
            acc(0, A_ERRST, 32'(j), "retry_log");
        end
        acc(1, A_ERRST, 32'h1, "");
        retry_mode <= 1'b0;
        // Error response subtypes on both sides
        for (int j = 0; j < 6; j++)
        begin
            send(1'b1, '{5'(j + 20), REQ_WR, 4'h3}, '{5'(j + 20), 1'b0, 4'h3, ec[j % 3], j >= 3});
            acc(0, (j >= 3) ? A_SSTAT : A_STAT, 32'h1 << eb[j % 3], "err_rsp");
            acc(1, (j >= 3) ? A_SSTAT : A_STAT, 32'hff, "");
        end
        // Driven aborts and posted data errors, even bits primary
        for (int j = 0; j < 8; j++)
        begin
            @(posedge clk);
            ev <= 8'h1 << j;
            @(posedge clk);
            ev <= 8'h0;
            acc(0, j[0] ? A_SSTAT : A_STAT, 32'h1 << ((j < 2) ? B_SIGTA : (j < 6) ? B_DEDET : B_MDERR), "event");
            acc(1, j[0] ? A_SSTAT : A_STAT, 32'hff, "");
        end
        // Forwarded aborts under both master abort modes
        for (int j = 0; j < 4; j++)
        begin
            acc(1, A_BRCTL, {29'h0, j[1], 2'h3}, "");
            @(posedge clk);
            fwd_err <= j[0] ? ERR_MA : ERR_TA;
            fwd_valid <= 1'b1;
            @(posedge clk);
            fwd_valid <= 1'b0;
            #1;
            chk("fwd", {29'h0, j[0], (j[0] & !j[1]) ? ERR_NONE : ERR_TA}, {29'h0, fwd_data_ones, fwd_out_err});
        end
        // Flood request refused, then taken once enabled
        acc(1, A_CMD, 32'h1, "");
        pulse(1'b0);
        chk("no_flood", 32'h1, {30'h0, &pri_tx_cad, &sec_tx_cad});
        acc(1, A_CMD, 32'h3, "");
        pulse(1'b0);
        chk("flood", 32'h6, {29'h0, &pri_tx_cad & pri_tx_ctl, &sec_tx_cad & sec_tx_ctl, pri_gen});
        acc(0, A_STAT, 32'h1 << B_SIGSE, "sig_serr");
        acc(0, A_ERRST, 32'h1 << B_CHFAIL, "chain_fail");
        pulse(1'b1);
        chk("warm", 32'h0, {31'h0, &pri_tx_cad});
        acc(0, A_ERRST, 32'h2, "persist");
        acc(1, A_ERRST, 32'h2, "");
        acc(1, A_STAT, 32'hff, "");
        // Flood arriving on the primary receiver
        @(posedge clk);
        flood_pri <= 1'b1;
        repeat (150) @(posedge clk);
        chk("rx_flood", 32'h6, {29'h0, &pri_tx_cad, &sec_tx_cad, pri_chk});
        acc(0, A_ERRST, 32'h2, "chain_fail_rx");
        flood_pri <= 1'b0;
        pulse(1'b1);
        acc(1, A_ERRST, 32'h2, "");
        // Secondary flood not passed up, turned into a nonfatal interrupt
        acc(1, A_BRCTL, 32'h1, "");
        acc(1, A_ERRHND, 32'h8, "");
        flood_sec <= 1'b1;
        repeat (150) @(posedge clk);
        chk("sec_flood", 32'h3, {29'h0, &pri_tx_cad, &sec_tx_cad, nonfatal_int});
        acc(0, A_SSTAT, 32'h1 << B_DETSE, "det_serr");
        acc(0, A_ERRST, 32'h6, "converted");
        tally_and_finish();
    end
endmodule
